// ---- dau_pkg.sv ----
// Purpose: Shared constants and types of the DMA address update block
// Assumes: APB register access, 32-bit data
// Notes: Offsets are byte addresses
package dau_pkg;
  localparam int ADDR_W = 32;
  localparam int PADDR_W = 8;
  localparam logic [7:0] OFF_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_SRC_ADDR = 8'h08;
  localparam logic [7:0] OFF_DST_ADDR = 8'h0C;
  localparam logic [7:0] OFF_OFFSET = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // Address control fields
  localparam int SRC_SEL_LSB = 20;
  localparam int DST_SEL_LSB = 16;
  localparam int SRC_OVF_IE_BIT = 15;
  localparam int AREA_LSB = 8;
  localparam int AREA_W = 5;
  localparam logic [31:0] ADDR_CTRL_WMASK = 32'h0033_9F00;
  localparam logic [31:0] ADDR_CTRL_RST = 32'h0000_0000;
  localparam logic [4:0] AREA_MIN = 5'h01;
  localparam logic [4:0] AREA_MAX = 5'h1A;
  // Mode register fields
  localparam int CTE_BIT = 0;
  localparam int END_FLAG_BIT = 1;
  localparam int BLK_BIT = 2;
  localparam int SGL_BIT = 3;
  localparam int SGL_SRC_BIT = 4;
  localparam int SIZE_LSB = 8;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [2:0] STEP_BYTE = 3'h1;
  localparam logic [2:0] STEP_WORD = 3'h2;
  localparam logic [2:0] STEP_LONG = 3'h4;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // Interrupt events
  localparam int IRQ_N = 2;
  localparam int EV_SRC_STOP = 0;
  localparam int EV_AREA_WRAP = 1;
  typedef enum logic [1:0] {
    UPD_FIXED = 2'h0,
    UPD_OFFSET = 2'h1,
    UPD_INC = 2'h2,
    UPD_DEC = 2'h3
  } dau_upd_t;
  typedef enum logic [1:0] {
    S_RUN = 2'h1,
    S_PEND = 2'h2
  } dau_state_t;
endpackage

// ---- dau_upd_if.sv ----
// Purpose: Carrier between channel control and one address updater
// Assumes: Updater is purely combinational
// Notes: One instance per address register
`timescale 1ns/1ps
`default_nettype none
interface dau_upd_if #(parameter int AW = 32);
  logic [AW-1:0] addr;
  logic [AW-1:0] offset;
  logic [AW-1:0] area_mask;
  logic [1:0] sel;
  logic [2:0] step;
  logic area_en;
  logic [AW-1:0] next_addr;
  logic ovf;
  modport ctrl (output addr, offset, area_mask, sel, step, area_en, input next_addr, ovf);
  modport upd (input addr, offset, area_mask, sel, step, area_en, output next_addr, ovf);
endinterface
`default_nettype wire

// ---- dau_addr_upd.sv ----
// Purpose: Next address for one address register after an access
// Assumes: Area mask is all ones over the updated low bits
// Notes: Overflow wraps to area start or end
`timescale 1ns/1ps
`default_nettype none
module dau_addr_upd
  import dau_pkg::*;
#(
  parameter int AW = 32
) (
  dau_upd_if.upd u
);
  logic [AW-1:0] raw;
  logic [AW-1:0] upper;
  logic dec;
  always_comb begin
    raw = u.addr;
    dec = 1'b0;
    unique case (u.sel)
      UPD_FIXED: raw = u.addr;
      UPD_OFFSET: raw = u.addr + u.offset;
      UPD_INC: raw = u.addr + AW'(u.step);
      UPD_DEC: begin
        raw = u.addr - AW'(u.step);
        dec = 1'b1;
      end
    endcase
    upper = u.addr & ~u.area_mask;
    u.ovf = u.area_en && (((raw ^ u.addr) & ~u.area_mask) != '0);
    if (u.ovf) begin
      u.next_addr = dec ? (upper | u.area_mask) : upper;
    end else begin
      u.next_addr = u.area_en ? (upper | (raw & u.area_mask)) : raw;
    end
  end
endmodule
`default_nettype wire

// ---- dau_irq.sv ----
// Purpose: Sticky event status, mask and one level interrupt
// Assumes: Events are one-cycle pulses
// Notes: Status clears by writing one; a new event wins over the clear
`timescale 1ns/1ps
`default_nettype none
module dau_irq
  import dau_pkg::*;
#(
  parameter int N = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [N-1:0] evt,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  logic [N-1:0] status_q, status_d, mask_q, mask_d;
  generate
    if (N < 1 || N > 32) begin : g_bad
      $error("dau_irq: N must be 1 to 32");
    end
  endgenerate
  always_comb begin
    status_d = (status_q & ~(clr_we ? wdata : '0)) | evt;
    mask_d = mask_we ? wdata : mask_q;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= '0;
      mask_q <= '0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end
  assign status = status_q;
  assign mask = mask_q;
  assign irq = |(status_q & mask_q);
endmodule
`default_nettype wire

// ---- dau_top.sv ----
// Purpose: Per-channel DMA address update and source area overflow stop
// Assumes: Sequencer pulses access_done per access and block_end per block
// Notes: APB slave with zero wait states
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Source select 00 holds address; 01 adds programmed offset each access
// - Source select 10 adds access size, 11 subtracts it, each access
// - Single address mode ignores source select unless source register is used
// - Destination select 00 holds address; 01 adds offset each access
// - Destination select 10 adds access size, 11 subtracts it, each access
// - Single address mode ignores destination select unless destination is used
// - Enabled source area overflow clears transfer enable; enable resets to 0
// - Same overflow sets end status flag to request the interrupt
// - In block mode the stop waits until the current block completes
// - Setting enable again resumes from saved addresses, no restart
// - Overflow interrupt enable ignored when no source area is configured
// - Control bits 19, 18, 14, 13 read zero and ignore writes
// - Area overflow wraps to start when adding, to end when subtracting
module dau_top
  import dau_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic access_done,
  input wire logic block_end,
  output logic [AW-1:0] src_addr,
  output logic [AW-1:0] dst_addr,
  output logic channel_transfer_enable,
  output logic channel_end_status_flag,
  output logic irq
);
  generate
    if (AW != 32) begin : g_bad
      $error("dau_top: AW must be 32");
    end
  endgenerate

  logic [31:0] ctrl_q, ctrl_d;
  logic cte_q, cte_d;
  logic end_flag_q, end_flag_d;
  logic blk_q, blk_d;
  logic sgl_q, sgl_d;
  logic sgl_src_q, sgl_src_d;
  logic [1:0] size_q, size_d;
  logic [AW-1:0] src_q, src_d;
  logic [AW-1:0] dst_q, dst_d;
  logic [AW-1:0] off_q, off_d;
  logic [31:0] prdata_q, prdata_d;
  dau_state_t st_q, st_d;

  logic wr, rd_setup, hit;
  logic wr_ctrl, wr_mode, wr_src, wr_dst, wr_off, wr_stat, wr_mask;
  logic [IRQ_N-1:0] irq_status, irq_mask, irq_evt;
  logic [AREA_W-1:0] area_code;
  logic area_en;
  logic [AW-1:0] area_mask;
  logic [2:0] step;
  logic [1:0] src_sel, dst_sel;
  logic step_ok, src_ovf_en, stop;

  dau_upd_if #(.AW(AW)) s_if ();
  dau_upd_if #(.AW(AW)) d_if ();

  // Bus decode
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      OFF_ADDR_CTRL, OFF_MODE, OFF_SRC_ADDR, OFF_DST_ADDR,
      OFF_OFFSET, OFF_IRQ_STATUS, OFF_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign wr_ctrl = wr && paddr == OFF_ADDR_CTRL;
  assign wr_mode = wr && paddr == OFF_MODE;
  assign wr_src = wr && paddr == OFF_SRC_ADDR;
  assign wr_dst = wr && paddr == OFF_DST_ADDR;
  assign wr_off = wr && paddr == OFF_OFFSET;
  assign wr_stat = wr && paddr == OFF_IRQ_STATUS;
  assign wr_mask = wr && paddr == OFF_IRQ_MASK;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Source extended area: size 2^(code+1) bytes
  assign area_code = ctrl_q[AREA_LSB +: AREA_W];
  assign area_en = (area_code >= AREA_MIN) && (area_code <= AREA_MAX);
  assign area_mask = ~({AW{1'b1}} << (area_code + 5'h01));

  always_comb begin
    step = STEP_BYTE;
    unique case (size_q)
      SIZE_WORD: step = STEP_WORD;
      SIZE_LONG: step = STEP_LONG;
      default: step = STEP_BYTE;
    endcase
  end

  // Effective update selects
  always_comb begin
    src_sel = ctrl_q[SRC_SEL_LSB +: 2];
    dst_sel = ctrl_q[DST_SEL_LSB +: 2];
    if (sgl_q && !sgl_src_q) begin
      src_sel = UPD_FIXED;
    end
    if (sgl_q && sgl_src_q) begin
      dst_sel = UPD_FIXED;
    end
  end

  // Source updater
  assign s_if.addr = src_q;
  assign s_if.offset = off_q;
  assign s_if.sel = src_sel;
  assign s_if.step = step;
  assign s_if.area_en = area_en;
  assign s_if.area_mask = area_mask;
  dau_addr_upd #(.AW(AW)) u_src (
    .u(s_if.upd)
  );

  // Destination updater, no extended area on this side
  assign d_if.addr = dst_q;
  assign d_if.offset = off_q;
  assign d_if.sel = dst_sel;
  assign d_if.step = step;
  assign d_if.area_en = 1'b0;
  assign d_if.area_mask = '0;
  dau_addr_upd #(.AW(AW)) u_dst (
    .u(d_if.upd)
  );

  assign step_ok = access_done & cte_q;
  assign src_ovf_en = ctrl_q[SRC_OVF_IE_BIT] & area_en;

  // Overflow stop sequencing
  always_comb begin
    st_d = st_q;
    stop = 1'b0;
    unique case (st_q)
      S_RUN: begin
        if (step_ok && s_if.ovf && src_ovf_en) begin
          if (blk_q) begin
            st_d = S_PEND;
          end else begin
            stop = 1'b1;
          end
        end
      end
      S_PEND: begin
        if (block_end) begin
          stop = 1'b1;
          st_d = S_RUN;
        end
      end
      default: st_d = S_RUN;
    endcase
  end

  // Register next values
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = pwdata & ADDR_CTRL_WMASK;
    end
    cte_d = cte_q;
    blk_d = blk_q;
    sgl_d = sgl_q;
    sgl_src_d = sgl_src_q;
    size_d = size_q;
    if (wr_mode) begin
      cte_d = pwdata[CTE_BIT];
      blk_d = pwdata[BLK_BIT];
      sgl_d = pwdata[SGL_BIT];
      sgl_src_d = pwdata[SGL_SRC_BIT];
      size_d = pwdata[SIZE_LSB +: 2];
    end
    if (stop) begin
      cte_d = 1'b0;
    end
    end_flag_d = (end_flag_q & ~(wr_mode & pwdata[END_FLAG_BIT])) | stop;
    src_d = src_q;
    if (step_ok) begin
      src_d = s_if.next_addr;
    end
    if (wr_src) begin
      src_d = pwdata;
    end
    dst_d = dst_q;
    if (step_ok) begin
      dst_d = d_if.next_addr;
    end
    if (wr_dst) begin
      dst_d = pwdata;
    end
    off_d = wr_off ? pwdata : off_q;
  end

  // Read data captured in the setup phase
  always_comb begin
    prdata_d = prdata_q;
    if (rd_setup) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        OFF_ADDR_CTRL: prdata_d = ctrl_q;
        OFF_MODE: begin
          prdata_d[CTE_BIT] = cte_q;
          prdata_d[END_FLAG_BIT] = end_flag_q;
          prdata_d[BLK_BIT] = blk_q;
          prdata_d[SGL_BIT] = sgl_q;
          prdata_d[SGL_SRC_BIT] = sgl_src_q;
          prdata_d[SIZE_LSB +: 2] = size_q;
        end
        OFF_SRC_ADDR: prdata_d = src_q;
        OFF_DST_ADDR: prdata_d = dst_q;
        OFF_OFFSET: prdata_d = off_q;
        OFF_IRQ_STATUS: prdata_d[IRQ_N-1:0] = irq_status;
        OFF_IRQ_MASK: prdata_d[IRQ_N-1:0] = irq_mask;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Addresses are never reset by a stop, so a re-enable resumes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= ADDR_CTRL_RST;
      cte_q <= 1'b0;
      end_flag_q <= 1'b0;
      blk_q <= 1'b0;
      sgl_q <= 1'b0;
      sgl_src_q <= 1'b0;
      size_q <= SIZE_BYTE;
      src_q <= WORD_RST;
      dst_q <= WORD_RST;
      off_q <= WORD_RST;
    end else begin
      ctrl_q <= ctrl_d;
      cte_q <= cte_d;
      end_flag_q <= end_flag_d;
      blk_q <= blk_d;
      sgl_q <= sgl_d;
      sgl_src_q <= sgl_src_d;
      size_q <= size_d;
      src_q <= src_d;
      dst_q <= dst_d;
      off_q <= off_d;
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata_q <= WORD_RST;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Overflow stop state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= S_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // Interrupt events
  assign irq_evt[EV_SRC_STOP] = stop;
  assign irq_evt[EV_AREA_WRAP] = step_ok & (s_if.ovf | d_if.ovf);
  dau_irq #(.N(IRQ_N)) u_irq (
    .clk(clk),
    .rstn(rstn),
    .evt(irq_evt),
    .clr_we(wr_stat),
    .mask_we(wr_mask),
    .wdata(pwdata[IRQ_N-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  assign prdata = prdata_q;
  assign src_addr = src_q;
  assign dst_addr = dst_q;
  assign channel_transfer_enable = cte_q;
  assign channel_end_status_flag = end_flag_q;
endmodule
`default_nettype wire

// ---- dau_props.sv ----
// Purpose: Port assertions for the DMA address update block
// Assumes: Zero wait state APB
// Notes: Bound to dau_top
`timescale 1ns/1ps
`default_nettype none
module dau_props
  import dau_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic access_done,
  input wire logic block_end,
  input wire logic [AW-1:0] src_addr,
  input wire logic [AW-1:0] dst_addr,
  input wire logic channel_transfer_enable,
  input wire logic channel_end_status_flag,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic wr;
  logic wr_mode;
  assign wr = psel && penable && pwrite;
  assign wr_mode = wr && (paddr == OFF_MODE);
  chk_addr_hold:
    assert property (!access_done && !wr |=> $stable(src_addr) && $stable(dst_addr))
    else $error("address moved without access");
  chk_off_hold:
    assert property (access_done && !channel_transfer_enable && !wr |=> $stable(src_addr))
    else $error("address moved while disabled");
  chk_stop_flag:
    assert property ($fell(channel_transfer_enable) && $past(rstn) && !$past(wr_mode)
      |-> channel_end_status_flag)
    else $error("stop without end flag");
  chk_flag_stop:
    assert property ($rose(channel_end_status_flag) |-> !channel_transfer_enable)
    else $error("end flag with enable high");
  chk_flag_cause:
    assert property ($rose(channel_end_status_flag) |-> $past(access_done) || $past(block_end))
    else $error("end flag without access or block end");
  chk_resv_zero:
    assert property (psel && penable && !pwrite && paddr == OFF_ADDR_CTRL
      |-> prdata[19:18] == 2'h0 && prdata[14:13] == 2'h0)
    else $error("reserved control bits not zero");
  chk_resume_keep:
    assert property ($rose(channel_transfer_enable) |-> src_addr == $past(src_addr))
    else $error("source address changed on resume");
  chk_reset_vals:
    assert property ($rose(rstn) |-> !channel_transfer_enable && !channel_end_status_flag && !irq)
    else $error("bad value after reset");
  cover property ($rose(channel_end_status_flag));
  cover property ($rose(channel_transfer_enable));
  cover property (irq);
  cover property (pslverr);
endmodule
bind dau_top dau_props #(.AW(AW)) dau_props_i (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .access_done(access_done), .block_end(block_end), .src_addr(src_addr), .dst_addr(dst_addr),
  .channel_transfer_enable(channel_transfer_enable),
  .channel_end_status_flag(channel_end_status_flag), .irq(irq));
`default_nettype wire

// ---- dau_seq_model.sv ----
// Purpose: Sequencer model pulsing access and block completion
// Assumes: One block per start pulse
// Notes: Slow mode idles one cycle between accesses
`timescale 1ns/1ps
`default_nettype none
module dau_seq_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] nacc,
  input wire logic slow,
  output logic access_done,
  output logic block_end,
  output logic busy
);
  logic [7:0] cnt_q;
  logic ph_q;
  always @(posedge clk) begin
    access_done <= 1'b0;
    block_end <= 1'b0;
    if (!rstn) begin
      busy <= 1'b0;
      cnt_q <= 8'h00;
      ph_q <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      cnt_q <= nacc;
      ph_q <= 1'b0;
    end else if (busy) begin
      ph_q <= slow & ~ph_q;
      if (cnt_q == 8'h00) begin
        block_end <= 1'b1;
        busy <= 1'b0;
      end else if (!ph_q) begin
        access_done <= 1'b1;
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dau_top_tb_top.sv ----
// Purpose: Self-checking bench for the DMA address update block
// Assumes: APB master tasks, sequencer model
// Notes: Expectations computed from programmed fields
`timescale 1ns/1ps
`default_nettype none
module dau_top_tb_top;
  import dau_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic start = 1'b0, slow = 1'b0, err;
  logic [7:0] paddr = 8'h00, nacc = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata, src_addr, dst_addr;
  logic pready, pslverr, access_done, block_end, busy, irq, cte, esf;
  int n_mismatch = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  dau_top dau_top_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .access_done(access_done), .block_end(block_end), .src_addr(src_addr),
    .dst_addr(dst_addr), .channel_transfer_enable(cte), .channel_end_status_flag(esf),
    .irq(irq));
  dau_seq_model dau_seq_model_i (.clk(clk), .rstn(rstn), .start(start), .nacc(nacc),
    .slow(slow), .access_done(access_done), .block_end(block_end), .busy(busy));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [7:0] n, input logic s);
    @(posedge clk);
    start <= 1'b1;
    nacc <= n;
    slow <= s;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] m, input logic [31:0] s);
    apb(1'b1, OFF_ADDR_CTRL, c);
    apb(1'b1, OFF_OFFSET, 32'hFFFF_FFF0);
    apb(1'b1, OFF_SRC_ADDR, s);
    apb(1'b1, OFF_DST_ADDR, 32'h2000);
    apb(1'b1, OFF_MODE, m);
  endtask
  function automatic logic [31:0] dl(input int s, input int z);
    case (s)
      0: return 32'h0;
      1: return 32'hFFFF_FFF0;
      2: return 32'h1 << z;
      default: return -(32'h1 << z);
    endcase
  endfunction
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a <= 28; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'(a == 28));
    end
    apb(1'b1, OFF_ADDR_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, OFF_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0033_9F00);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      for (int z = 0; z < 3; z++) begin
        cfg(32'(s) << 20 | 32'(3 - s) << 16, 32'h1 | 32'(z) << 8, 32'h1000);
        run(8'h03, z[0]);
        chk(src_addr, 32'h1000 + 3 * dl(s, z));
        chk(dst_addr, 32'h2000 + 3 * dl(3 - s, z));
      end
    end
    for (int k = 0; k < 2; k++) begin
      cfg(32'h0022_0000, 32'h9 | 32'(k) << 4, 32'h1000);
      run(8'h02, 1'b0);
      chk(src_addr, k ? 32'h1002 : 32'h1000);
      chk(dst_addr, k ? 32'h2000 : 32'h2002);
    end
    $display("test update modes done");
    cfg(32'h0020_8100, 32'h1, 32'h10FE);
    run(8'h04, 1'b1);
    chk(src_addr, 32'h10FC);
    chk(32'({cte, esf}), 32'h1);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFF_IRQ_STATUS, 32'h1);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk({rd[30:0], irq}, 32'h4);
    apb(1'b1, OFF_MODE, 32'h2);
    apb(1'b1, OFF_MODE, 32'h1);
    chk(src_addr, 32'h10FC);
    run(8'h01, 1'b0);
    chk(src_addr, 32'h10FD);
    $display("test overflow stop done");
    apb(1'b1, OFF_ADDR_CTRL, 32'h0030_0100);
    run(8'h02, 1'b0);
    chk(src_addr, 32'h10FF);
    apb(1'b1, OFF_ADDR_CTRL, 32'h0020_8000);
    run(8'h01, 1'b0);
    chk(src_addr, 32'h1100);
    chk(32'({cte, esf}), 32'h2);
    $display("test wrap done");
    cfg(32'h0020_8100, 32'h5, 32'h10FE);
    run(8'h04, 1'b1);
    chk(src_addr, 32'h10FE);
    chk(32'({cte, esf}), 32'h1);
    $display("test block done");
    close_out();
  end
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
